/* File: pkg/rfirq_pkg.sv */
// Constants and carrier types for the receiver setting and interrupt register bank.
// Assumes an APB master with 32-bit data and word-aligned register access.

package rfirq_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] RFIRQ_IDX_PROTOCOL_CTRL = 8'h01;
  localparam logic [7:0] RFIRQ_IDX_RX_FILTER     = 8'h0a;
  localparam logic [7:0] RFIRQ_IDX_REG_IO        = 8'h0b;
  localparam logic [7:0] RFIRQ_IDX_IRQ_STATUS    = 8'h0c;
  localparam logic [7:0] RFIRQ_IDX_IRQ_MASK      = 8'h0d;
  localparam logic [7:0] RFIRQ_IDX_COLL_POS      = 8'h0e;

  // ****************************************************************
  // Reset values and write masks
  // ****************************************************************
  localparam logic [7:0] RFIRQ_RST_PROTOCOL_CTRL = 8'h00;
  localparam logic [7:0] RFIRQ_RST_RX_FILTER     = 8'h40;
  localparam logic [7:0] RFIRQ_RST_REG_IO        = 8'h87;
  localparam logic [7:0] RFIRQ_RST_IRQ_STATUS    = 8'h00;
  localparam logic [7:0] RFIRQ_RST_IRQ_MASK      = 8'h3e;
  localparam logic [7:0] RFIRQ_RST_COLL_POS      = 8'h00;
  localparam logic [7:0] RFIRQ_WMASK_RX_FILTER   = 8'hfc;
  localparam logic [7:0] RFIRQ_WMASK_REG_IO      = 8'he7;

  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int RFIRQ_BIT_TX        = 7;
  localparam int RFIRQ_BIT_RX        = 6;
  localparam int RFIRQ_BIT_FIFO      = 5;
  localparam int RFIRQ_BIT_CRC       = 4;
  localparam int RFIRQ_BIT_PARITY    = 3;
  localparam int RFIRQ_BIT_FRAMING   = 2;
  localparam int RFIRQ_BIT_COLLISION = 1;
  localparam int RFIRQ_BIT_NORESP    = 0;

  // ****************************************************************
  // FIFO level thresholds and gain reduction steps in dB
  // ****************************************************************
  localparam logic [3:0] RFIRQ_FIFO_LOW_LIMIT  = 4'h4;
  localparam logic [3:0] RFIRQ_FIFO_HIGH_LIMIT = 4'h8;
  localparam logic [4:0] RFIRQ_GAIN_DB_CODE1   = 5'h05;
  localparam logic [4:0] RFIRQ_GAIN_DB_CODE2   = 5'h0a;
  localparam logic [4:0] RFIRQ_GAIN_DB_CODE3   = 5'h0f;
  localparam logic [4:0] RFIRQ_GAIN_DB_HBR     = 5'h07;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rfirq_apb_req_t;

  typedef struct packed {
    logic tx_start;
    logic tx_end;
    logic rx_sof;
    logic rx_end;
    logic crc_error_event;
    logic parity_error_event;
    logic framing_error_event;
    logic collision_event;
    logic no_response_event;
  } rfirq_events_t;

  typedef struct packed {
    logic filter_sel_212k;
    logic filter_sel_424k;
    logic filter_sel_848k_manchester;
    logic filter_sel_high_bit_rate;
    logic gain_reduce_bit_a;
    logic gain_reduce_bit_b;
  } rfirq_rx_cfg_t;

  typedef struct packed {
    logic       auto_regulator;
    logic       external_amplifier_support;
    logic       io_low_voltage;
    logic [1:0] unused_bits;
    logic       voltage_select_2;
    logic       voltage_select_1;
    logic       voltage_select_0;
  } rfirq_reg_io_t;

  typedef struct packed {
    logic [7:0]  protocol_ctrl;
    logic [7:0]  rx_filter;
    logic [7:0]  reg_io;
    logic [7:0]  status;
    logic [5:0]  int_enable;
    logic [1:0]  collision_hi;
    logic [7:0]  collision_lo;
    logic        tx_done_pend;
    logic        rx_done_pend;
    logic        fifo_cond;
    logic        irq;
    logic [4:0]  gain_db;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rfirq_state_t;

endpackage

/* File: src/rfirq_regs.sv */
// Receiver filter and gain settings, regulator options, interrupt status and mask registers.
// Assumes synchronous event pulses from the framing logic and an APB master on sys_clk.
//
// Behaviour
// RULE1 - Receiver setting resets 0x40, also on protocol write
// RULE2 - Bits 7..5 select three band-pass filters
// RULE3 - Bit 4 widest filter, gain minus 7 dB
// RULE4 - Bits 3:2 reduce gain 5, 10, 15 dB
// RULE5 - Regulator register resets 0x87, protocol write ignored
// RULE6 - Bit 7 selects automatic regulator setting
// RULE7 - Bit 6 enables external amplifier support
// RULE8 - Host sets bit 5 below 2.7 V supply
// RULE9 - Bits 2:0 voltage select, bits 4:3 low
// RULE10 - Status resets 0x00, clears on read, drops request
// RULE11 - Bit 7 set at transmit start, request at end
// RULE12 - Bit 6 set at start-of-frame, request at end
// RULE13 - Bit 5 flags FIFO below 4 or above 8
// RULE14 - Bits 4..2 flag CRC, parity, framing errors
// RULE15 - Bit 1 flags collision in capable protocols only
// RULE16 - Bit 0 flags no-response timeout
// RULE17 - Mask register resets to 0x3e
// RULE18 - Mask bits 7:6 hold collision position high bits
// RULE19 - Mask bits 5..0 enable individual event interrupts
// RULE20 - Collision position resets 0x00, clears on read
// RULE21 - Position register holds low eight position bits
// RULE22 - Request asserts for enabled events, transmit/receive always

module rfirq_regs
  import rfirq_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  input  wire logic           chip_en,
  input  wire rfirq_apb_req_t apb_req,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire rfirq_events_t  events,
  input  wire logic [3:0]     fifo_count,
  input  wire logic           collision_capable,
  input  wire logic [9:0]     event_position,
  output logic                irq,
  output rfirq_rx_cfg_t       rx_cfg,
  output logic [4:0]          rx_gain_reduce_db,
  output rfirq_reg_io_t       reg_io
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
    reg_hit = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
  endfunction

  function automatic logic reg_mapped(input logic [11:0] addr);
    reg_mapped = reg_hit(addr, RFIRQ_IDX_PROTOCOL_CTRL) || reg_hit(addr, RFIRQ_IDX_RX_FILTER)
              || reg_hit(addr, RFIRQ_IDX_REG_IO) || reg_hit(addr, RFIRQ_IDX_IRQ_STATUS)
              || reg_hit(addr, RFIRQ_IDX_IRQ_MASK) || reg_hit(addr, RFIRQ_IDX_COLL_POS);
  endfunction

  function automatic logic [4:0] gain_db(input logic [7:0] cfg);
    logic [4:0] base;
    base = 5'h00;
    unique case (cfg[3:2])
      2'b01: base = RFIRQ_GAIN_DB_CODE1;
      2'b10: base = RFIRQ_GAIN_DB_CODE2;
      2'b11: base = RFIRQ_GAIN_DB_CODE3;
      2'b00: base = 5'h00;
    endcase
    gain_db = cfg[4] ? base + RFIRQ_GAIN_DB_HBR : base;
  endfunction

  // ****************************************************************
  // Reset release
  // ****************************************************************
  // The raw reset is released through two flops so that no register sees a
  // release edge close to the clock.
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  rfirq_state_t state_reg;
  rfirq_state_t state_next;

  localparam rfirq_state_t RFIRQ_STATE_RESET = '{
    protocol_ctrl: RFIRQ_RST_PROTOCOL_CTRL,
    rx_filter:     RFIRQ_RST_RX_FILTER,
    reg_io:        RFIRQ_RST_REG_IO,
    status:        RFIRQ_RST_IRQ_STATUS,
    int_enable:    RFIRQ_RST_IRQ_MASK[5:0],
    collision_hi:  RFIRQ_RST_IRQ_MASK[7:6],
    collision_lo:  RFIRQ_RST_COLL_POS,
    tx_done_pend:  1'b0,
    rx_done_pend:  1'b0,
    // Starting as already met keeps an empty FIFO from flagging at power-up.
    fifo_cond:     1'b1,
    irq:           1'b0,
    gain_db:       5'h00,
    pready:        1'b0,
    pslverr:       1'b0,
    prdata:        32'h0000_0000
  };

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic       access;
    logic       done;
    logic       wr_done;
    logic       rd_done;
    logic       fifo_now;
    logic       pos_capture;
    logic [7:0] rd_value;
    access      = apb_req.psel && apb_req.penable;
    done        = access && state_reg.pready;
    wr_done     = done && apb_req.pwrite && !state_reg.pslverr;
    rd_done     = done && !apb_req.pwrite && !state_reg.pslverr;
    fifo_now    = (fifo_count < RFIRQ_FIFO_LOW_LIMIT) || (fifo_count > RFIRQ_FIFO_HIGH_LIMIT);
    pos_capture = (events.collision_event && collision_capable) || events.crc_error_event
               || events.parity_error_event || events.framing_error_event;
    rd_value    = 8'h00;
    state_next  = state_reg;

    // One wait state: pready rises in the second access cycle.
    state_next.pready  = access && !state_reg.pready;
    state_next.pslverr = access && !state_reg.pready && !reg_mapped(apb_req.paddr);
    if (reg_hit(apb_req.paddr, RFIRQ_IDX_PROTOCOL_CTRL)) begin
      rd_value = state_reg.protocol_ctrl;
    end else if (reg_hit(apb_req.paddr, RFIRQ_IDX_RX_FILTER)) begin
      rd_value = state_reg.rx_filter;
    end else if (reg_hit(apb_req.paddr, RFIRQ_IDX_REG_IO)) begin
      rd_value = state_reg.reg_io;
    end else if (reg_hit(apb_req.paddr, RFIRQ_IDX_IRQ_STATUS)) begin
      rd_value = state_reg.status;
    end else if (reg_hit(apb_req.paddr, RFIRQ_IDX_IRQ_MASK)) begin
      rd_value = {state_reg.collision_hi, state_reg.int_enable};
    end else if (reg_hit(apb_req.paddr, RFIRQ_IDX_COLL_POS)) begin
      rd_value = state_reg.collision_lo;
    end
    state_next.prdata = (access && !state_reg.pready && !apb_req.pwrite)
                      ? {24'h00_0000, rd_value} : 32'h0000_0000;

    // Register writes.
    if (wr_done && reg_hit(apb_req.paddr, RFIRQ_IDX_RX_FILTER)) begin
      state_next.rx_filter = apb_req.pwdata[7:0] & RFIRQ_WMASK_RX_FILTER;  // [RULE2] [RULE3]
    end
    if (wr_done && reg_hit(apb_req.paddr, RFIRQ_IDX_REG_IO)) begin
      state_next.reg_io = apb_req.pwdata[7:0] & RFIRQ_WMASK_REG_IO;  // [RULE6] [RULE7] [RULE9]
    end
    if (wr_done && reg_hit(apb_req.paddr, RFIRQ_IDX_IRQ_MASK)) begin
      state_next.int_enable = apb_req.pwdata[5:0];  // [RULE19]
    end
    if (wr_done && reg_hit(apb_req.paddr, RFIRQ_IDX_PROTOCOL_CTRL)) begin
      state_next.protocol_ctrl = apb_req.pwdata[7:0];
      // A protocol change restores receiver and status defaults only.
      state_next.rx_filter    = RFIRQ_RST_RX_FILTER;  // [RULE1] [RULE5]
      state_next.status       = RFIRQ_RST_IRQ_STATUS;  // [RULE10]
      state_next.tx_done_pend = 1'b0;
      state_next.rx_done_pend = 1'b0;
    end

    // Clear-on-read, applied at the edge that completes the read.
    if (rd_done && reg_hit(apb_req.paddr, RFIRQ_IDX_IRQ_STATUS)) begin
      state_next.status       = RFIRQ_RST_IRQ_STATUS;  // [RULE10]
      state_next.tx_done_pend = 1'b0;
      state_next.rx_done_pend = 1'b0;
    end
    if (rd_done && reg_hit(apb_req.paddr, RFIRQ_IDX_IRQ_MASK)) begin
      state_next.collision_hi = 2'b00;  // [RULE18]
    end
    if (rd_done && reg_hit(apb_req.paddr, RFIRQ_IDX_COLL_POS)) begin
      state_next.collision_lo = RFIRQ_RST_COLL_POS;  // [RULE20]
    end

    // Events come after the read and protocol-write clears so a set in the clearing cycle is never lost.
    state_next.fifo_cond = fifo_now;
    if (events.tx_start) begin
      state_next.status[RFIRQ_BIT_TX] = 1'b1;  // [RULE11]
    end
    if (events.tx_end) begin
      state_next.tx_done_pend = 1'b1;  // [RULE11]
    end
    if (events.rx_sof) begin
      state_next.status[RFIRQ_BIT_RX] = 1'b1;  // [RULE12]
    end
    if (events.rx_end) begin
      state_next.rx_done_pend = 1'b1;  // [RULE12]
    end
    if (fifo_now && !state_reg.fifo_cond) begin
      state_next.status[RFIRQ_BIT_FIFO] = 1'b1;  // [RULE13]
    end
    if (events.crc_error_event) begin
      state_next.status[RFIRQ_BIT_CRC] = 1'b1;  // [RULE14]
    end
    if (events.parity_error_event) begin
      state_next.status[RFIRQ_BIT_PARITY] = 1'b1;  // [RULE14]
    end
    if (events.framing_error_event) begin
      state_next.status[RFIRQ_BIT_FRAMING] = 1'b1;  // [RULE14]
    end
    if (events.collision_event && collision_capable) begin
      state_next.status[RFIRQ_BIT_COLLISION] = 1'b1;  // [RULE15]
    end
    if (events.no_response_event) begin
      state_next.status[RFIRQ_BIT_NORESP] = 1'b1;  // [RULE16]
    end
    if (pos_capture) begin
      state_next.collision_hi = event_position[9:8];  // [RULE18]
      state_next.collision_lo = event_position[7:0];  // [RULE21]
    end

    // Chip disable restores every register default, as at power-on.
    if (!chip_en) begin
      state_next.protocol_ctrl = RFIRQ_RST_PROTOCOL_CTRL;
      state_next.rx_filter     = RFIRQ_RST_RX_FILTER;  // [RULE1]
      state_next.reg_io        = RFIRQ_RST_REG_IO;  // [RULE5]
      state_next.status        = RFIRQ_RST_IRQ_STATUS;  // [RULE10]
      state_next.int_enable    = RFIRQ_RST_IRQ_MASK[5:0];  // [RULE17]
      state_next.collision_hi  = RFIRQ_RST_IRQ_MASK[7:6];
      state_next.collision_lo  = RFIRQ_RST_COLL_POS;  // [RULE20]
      state_next.tx_done_pend  = 1'b0;
      state_next.rx_done_pend  = 1'b0;
    end

    // Only the end of a transfer raises the request for bits 7 and 6.
    state_next.irq = state_next.tx_done_pend || state_next.rx_done_pend
                  || |(state_next.status[5:0] & state_next.int_enable);  // [RULE22] [RULE10]
    state_next.gain_db = gain_db(state_next.rx_filter);  // [RULE3] [RULE4]
  end

  always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= RFIRQ_STATE_RESET;  // [RULE1] [RULE5] [RULE17] [RULE20]
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata            = state_reg.prdata;
  assign pready            = state_reg.pready;
  assign pslverr           = state_reg.pslverr;
  assign irq               = state_reg.irq;
  assign rx_cfg            = rfirq_rx_cfg_t'(state_reg.rx_filter[7:2]);
  assign rx_gain_reduce_db = state_reg.gain_db;
  assign reg_io            = rfirq_reg_io_t'(state_reg.reg_io);

endmodule

/* File: tb/rfirq_props.sv */
// Concurrent checks on the receiver setting and interrupt register bank.
// Assumes it is bound to rfirq_regs and sees only that module's ports.
module rfirq_props
  import rfirq_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           rst_n,
  input wire logic           chip_en,
  input wire rfirq_apb_req_t apb_req,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire rfirq_events_t  events,
  input wire logic [3:0]     fifo_count,
  input wire logic           collision_capable,
  input wire logic [9:0]     event_position,
  input wire logic           irq,
  input wire rfirq_rx_cfg_t  rx_cfg,
  input wire logic [4:0]     rx_gain_reduce_db,
  input wire rfirq_reg_io_t  reg_io
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] live_cnt;
  logic [5:0] mask_q;
  logic       live;
  logic       done;
  logic       wr_done;
  // The mask is mirrored from bus writes, since the design keeps it internal.
  assign live    = live_cnt == 3'd7;
  assign done    = apb_req.psel && apb_req.penable && pready;
  assign wr_done = done && apb_req.pwrite && !pslverr;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      live_cnt <= 3'd0;
      mask_q   <= 6'h3e;
    end else begin
      live_cnt <= live ? live_cnt : live_cnt + 3'd1;
      mask_q   <= !chip_en ? 6'h3e :
                  (wr_done && apb_req.paddr == 12'h034) ? apb_req.pwdata[5:0] : mask_q;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  chip_def_a: assert property (
    live && !chip_en |=> rx_cfg == 6'h10 && reg_io == 8'h87)
    else $error("defaults missing after chip disable");
  proto_def_a: assert property (
    live && chip_en && wr_done && apb_req.paddr == 12'h004
    |=> rx_cfg == 6'h10 && $stable(reg_io)) else $error("protocol write effect wrong");
  gain_map_a: assert property (
    rx_gain_reduce_db == 5'({rx_cfg.gain_reduce_bit_a, rx_cfg.gain_reduce_bit_b}) * 5'd5
    + (rx_cfg.filter_sel_high_bit_rate ? 5'd7 : 5'd0))
    else $error("gain reduction mismatch");
  unused_low_a: assert property (reg_io.unused_bits == 2'b00)
    else $error("unused regulator bits set");
  read_clear_a: assert property (
    live && chip_en && done && !apb_req.pwrite && !pslverr && apb_req.paddr == 12'h030 &&
    events == '0 && $stable(fifo_count) ##1 events == '0 && $stable(fifo_count)
    |=> !irq) else $error("request kept after status read");
  end_irq_a: assert property (
    live && chip_en && (events.tx_end || events.rx_end) |=> irq)
    else $error("no request at end of transfer");
  start_quiet_a: assert property (
    live && chip_en && $stable(chip_en) && !irq && !pready && $stable(fifo_count) &&
    (events == 9'h100 || events == 9'h040 || (events == 9'h002 && !collision_capable))
    |=> !irq) else $error("early request");
  err_irq_a: assert property (
    live && chip_en && !(done && apb_req.pwrite) &&
    |(events[4:0] & mask_q[4:0] & {3'b111, collision_capable, 1'b1}) |=> irq)
    else $error("enabled event gave no request");
  fifo_irq_a: assert property (
    live && chip_en && $stable(chip_en) && mask_q[5] && !done &&
    (fifo_count < 4'd4 || fifo_count > 4'd8) && $past(fifo_count) inside {[4'd4:4'd8]}
    |=> irq) else $error("fifo level gave no request");
endmodule
bind rfirq_regs rfirq_props u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .chip_en(chip_en), .apb_req(apb_req), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .events(events), .fifo_count(fifo_count),
  .collision_capable(collision_capable), .event_position(event_position), .irq(irq),
  .rx_cfg(rx_cfg), .rx_gain_reduce_db(rx_gain_reduce_db), .reg_io(reg_io)
);

/* File: tb/rfirq_host.sv */
// Bus master model standing in for the host controller.
// Assumes an APB slave on sys_clk that answers with pready.
module rfirq_host
  import rfirq_pkg::*;
#(
  parameter bit LOW_IO_SUPPLY = 1'b1
)
(
  input  wire logic      sys_clk,
  input  wire logic      pready,
  output rfirq_apb_req_t apb_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial apb_req = '0;
  // Released address and data lines show the inverse, so stale values never look valid.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] data);
    logic [31:0] d;
    d = data;
    if (w && a == 12'h02c && LOW_IO_SUPPLY) d[5] = 1'b1;
    @(posedge sys_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    @(posedge sys_clk);
    while (!pready) @(posedge sys_clk);
    apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
  endtask
endmodule

/* File: tb/rfirq_regs_tb_top.sv */
// Self-checking bench for the receiver setting and interrupt register bank.
// Assumes rfirq_host as bus master and the bound checker beside the design.
module rfirq_regs_tb_top
  import rfirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           sys_clk, rst_n, chip_en, collision_capable, pready, pslverr, irq;
  logic [31:0]    prdata;
  logic [3:0]     fifo_count;
  logic [9:0]     event_position, p;
  logic [4:0]     rx_gain_reduce_db;
  logic [7:0]     d;
  rfirq_apb_req_t apb_req;
  rfirq_events_t  events;
  rfirq_rx_cfg_t  rx_cfg;
  rfirq_reg_io_t  reg_io;
  logic [32:0]    exp_q[$];
  logic [3:0]     fv[5] = '{4'h4, 4'h8, 4'h3, 4'h6, 4'h9};
  logic [7:0]     fs[5] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h20};
  int             n_fail, samples_checked, cycles, seed;
  rfirq_host u_host (.sys_clk(sys_clk), .pready(pready), .apb_req(apb_req));
  rfirq_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .chip_en(chip_en), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
    .fifo_count(fifo_count), .collision_capable(collision_capable),
    .event_position(event_position), .irq(irq), .rx_cfg(rx_cfg),
    .rx_gain_reduce_db(rx_gain_reduce_db), .reg_io(reg_io));
  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic err = 1'b0);
    exp_q.push_back({err, 32'h0});
    u_host.xfer(1'b1, a, {24'($random(seed)), v});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] v, input logic err = 1'b0);
    exp_q.push_back({err, 24'h0, v});
    u_host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input logic [8:0] ev);
    @(posedge sys_clk);
    events <= ev;
    event_position <= 10'($random(seed));
    @(posedge sys_clk);
    events <= '0;
    #1;
  endtask
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (apb_req.psel && apb_req.penable && pready) begin
      chk("bus", exp_q.pop_front(), {pslverr, prdata});
    end
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      conclude();
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'he12a93c6;
    {rst_n, chip_en, collision_capable, events, event_position} = {3'b011, 19'h0};
    fifo_count = 4'h6;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("rx_cfg", 33'h10, 33'(rx_cfg));
    chk("reg_io", 33'h87, 33'(reg_io));
    rd(12'h028, 8'h40);
    rd(12'h02c, 8'h87);
    rd(12'h030, 8'h00);
    rd(12'h034, 8'h3e);
    rd(12'h038, 8'h00);
    rd(12'h03c, 8'h00, 1'b1);
    wr(12'h029, 8'hff, 1'b1);
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      d[4:2] = i[2:0];
      wr(12'h028, d);
      rd(12'h028, d & 8'hfc);
      chk("rx_cfg", 33'(d[7:2]), 33'(rx_cfg));
      chk("gain", 33'(d[3:2]) * 33'd5 + (d[4] ? 33'd7 : 33'd0),
          33'(rx_gain_reduce_db));
    end
    wr(12'h02c, 8'h5f);
    rd(12'h02c, 8'h67);
    chk("reg_io", 33'h67, 33'(reg_io));
    wr(12'h004, 8'($random(seed)));
    rd(12'h028, 8'h40);
    rd(12'h02c, 8'h67);
    for (int b = 4; b >= 0; b--) begin
      pulse(9'h1 << b);
      chk("irq", 33'(b != 0), 33'(irq));
      p = (b != 0) ? event_position : 10'h0;
      rd(12'h030, 8'(1 << b));
      rd(12'h038, p[7:0]);
      rd(12'h034, {p[9:8], 6'h3e});
      rd(12'h038, 8'h00);
      chk("irq", 33'h0, 33'(irq));
    end
    wr(12'h034, 8'h01);
    pulse(9'h010);
    chk("irq", 33'h0, 33'(irq));
    pulse(9'h001);
    chk("irq", 33'h1, 33'(irq));
    rd(12'h030, 8'h11);
    wr(12'h034, 8'h3e);
    collision_capable <= 1'b0;
    pulse(9'h002);
    chk("irq", 33'h0, 33'(irq));
    rd(12'h030, 8'h00);
    collision_capable <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      pulse(k ? 9'h040 : 9'h100);
      chk("irq", 33'h0, 33'(irq));
      pulse(k ? 9'h020 : 9'h080);
      chk("irq", 33'h1, 33'(irq));
      rd(12'h030, k ? 8'h40 : 8'h80);
      repeat (2) @(posedge sys_clk);
      #1 chk("irq", 33'h0, 33'(irq));
    end
    foreach (fv[i]) begin
      @(posedge sys_clk);
      fifo_count <= fv[i];
      rd(12'h030, fs[i]);
    end
    wr(12'h028, 8'hff);
    wr(12'h034, 8'h00);
    @(posedge sys_clk);
    chip_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chip_en <= 1'b1;
    rd(12'h028, 8'h40);
    rd(12'h02c, 8'h87);
    rd(12'h034, 8'h3e);
    repeat (2) @(posedge sys_clk);
    conclude();
  end
endmodule
